// >>> core/i2crg_pkg.sv
// Constants shared by the serial register target
package i2crg_pkg;
    // ==========================================================
    // Addressing
    localparam logic [6:0] I2CRG_SLAVE_ADDR   = 7'h6b;
    localparam logic [4:0] I2CRG_HS_CODE_HI   = 5'h01;
    localparam int         I2CRG_NUM_REGS     = 5;
    localparam logic [2:0] I2CRG_RO_INDEX     = 3'h3;
    localparam logic [2:0] I2CRG_LAST_INDEX   = 3'h4;
    localparam logic [7:0] I2CRG_UNMAPPED_VAL = 8'hff;
    // ==========================================================
    // Reset values of the writable registers
    localparam logic [7:0] I2CRG_RST_REG0 = 8'h40;
    localparam logic [7:0] I2CRG_RST_REG1 = 8'h30;
    localparam logic [7:0] I2CRG_RST_REG2 = 8'h0a;
    localparam logic [7:0] I2CRG_RST_REG4 = 8'h89;
    // ==========================================================
    // Byte framing
    localparam logic [3:0] I2CRG_BITS_PER_BYTE = 4'h8;
    localparam int         I2CRG_RW_BIT        = 0;
    // ==========================================================
    // Protocol states
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_ADDR   = 6'b000010,
        ST_REGA   = 6'b000100,
        ST_DATA   = 6'b001000,
        ST_READ   = 6'b010000,
        ST_IGNORE = 6'b100000
    } i2crg_state_t;
endpackage

// >>> core/i2crg_target.sv
// Serial bus target with five byte-wide registers
`timescale 1ns/1ps
// ==========================================================
module i2crg_target
    import i2crg_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    // Bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // Register contents
    input  wire logic [7:0] ident_i,
    output logic [7:0]      status_ctrl_o,
    output logic [7:0]      control_o,
    output logic [7:0]      batt_volt_o,
    output logic [7:0]      charge_cur_o,
    output logic            high_speed_operation_o
);
    // ==========================================================
    // Reset release and pin synchronisers
    logic       rst_meta_reg, rst_n;
    logic [1:0] scl_sync_reg, sda_sync_reg;
    logic       scl_d_reg, sda_d_reg;
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end
    // Idle bus is high, so the syncs reset high to avoid a false START
    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end
    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    assign scl_s     = scl_sync_reg[1];
    assign sda_s     = sda_sync_reg[1];
    assign scl_rise  = scl_s & ~scl_d_reg;
    assign scl_fall  = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    // ==========================================================
    // Register file
    logic [7:0] regs_reg [0:I2CRG_NUM_REGS-1], regs_next [0:I2CRG_NUM_REGS-1];
    function automatic logic [7:0] reset_value(input int idx);
        case (idx)
            0:       reset_value = I2CRG_RST_REG0;
            1:       reset_value = I2CRG_RST_REG1;
            2:       reset_value = I2CRG_RST_REG2;
            4:       reset_value = I2CRG_RST_REG4;
            default: reset_value = 8'h00;
        endcase
    endfunction
    // Index three is fed from outside, so its slot in the array stays idle
    function automatic logic [7:0] read_value(input logic [2:0] ptr, input logic [7:0] r0,
        input logic [7:0] r1, input logic [7:0] r2, input logic [7:0] ro, input logic [7:0] r4);
        case (ptr)
            3'h0:    read_value = r0;
            3'h1:    read_value = r1;
            3'h2:    read_value = r2;
            3'h3:    read_value = ro;
            3'h4:    read_value = r4;
            default: read_value = I2CRG_UNMAPPED_VAL;
        endcase
    endfunction
    // ==========================================================
    // Protocol engine
    i2crg_state_t state_reg, state_next;
    logic [3:0]   cnt_reg, cnt_next;
    logic         in_ack_reg, in_ack_next;
    logic         ack_drive_reg, ack_drive_next;
    logic [7:0]   shift_reg, shift_next;
    logic [7:0]   tx_reg, tx_next;
    logic         tx_en_reg, tx_en_next;
    logic [2:0]   ptr_reg, ptr_next;
    logic         hs_reg, hs_next;
    logic         ack_start, ack_end, addr_match, hs_code;
    logic [7:0]   rd_byte;
    assign ack_start  = scl_fall & (cnt_reg == I2CRG_BITS_PER_BYTE) & ~in_ack_reg;
    assign ack_end    = scl_fall & in_ack_reg;
    assign addr_match = (shift_reg[7:1] == I2CRG_SLAVE_ADDR);
    assign hs_code    = (shift_reg[7:3] == I2CRG_HS_CODE_HI);
    assign rd_byte    = read_value(ptr_reg, regs_reg[0], regs_reg[1], regs_reg[2],
                                   ident_i, regs_reg[4]);
    always_comb
    begin
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        in_ack_next    = in_ack_reg;
        ack_drive_next = ack_drive_reg;
        shift_next     = shift_reg;
        tx_next        = tx_reg;
        tx_en_next     = tx_en_reg;
        ptr_next       = ptr_reg;
        hs_next        = hs_reg;
        for (int i = 0; i < I2CRG_NUM_REGS; i++)
            regs_next[i] = regs_reg[i];
        if (stop_det)
        begin
            state_next     = ST_IDLE;
            hs_next        = 1'b0;
            ack_drive_next = 1'b0;
            tx_en_next     = 1'b0;
        end
        else if (start_det)
        begin
            state_next     = ST_ADDR;
            cnt_next       = 4'h0;
            in_ack_next    = 1'b0;
            ack_drive_next = 1'b0;
            tx_en_next     = 1'b0;
        end
        else if (state_reg != ST_IDLE && state_reg != ST_IGNORE)
        begin
            if (scl_rise && !in_ack_reg && cnt_reg < I2CRG_BITS_PER_BYTE)
            begin
                shift_next = {shift_reg[6:0], sda_s};
                cnt_next   = cnt_reg + 4'h1;
            end
            else if (scl_rise && in_ack_reg && state_reg == ST_READ && sda_s)
            begin
                // Master refused the byte: the read is over
                state_next = ST_IGNORE;
                tx_en_next = 1'b0;
            end
            else if (ack_start)
            begin
                in_ack_next = 1'b1;
                tx_en_next  = 1'b0;
                case (state_reg)
                    ST_ADDR:
                    begin
                        ack_drive_next = addr_match;
                        if (!addr_match && hs_code)
                            hs_next = 1'b1;
                    end
                    ST_REGA, ST_DATA: ack_drive_next = 1'b1;
                    default: ack_drive_next = 1'b0;
                endcase
            end
            else if (ack_end)
            begin
                in_ack_next    = 1'b0;
                ack_drive_next = 1'b0;
                cnt_next       = 4'h0;
                case (state_reg)
                    ST_ADDR:
                    begin
                        if (!addr_match)
                            state_next = ST_IGNORE;
                        else if (shift_reg[I2CRG_RW_BIT])
                        begin
                            state_next = ST_READ;
                            tx_next    = rd_byte;
                            tx_en_next = 1'b1;
                        end
                        else
                            state_next = ST_REGA;
                    end
                    ST_REGA:
                    begin
                        ptr_next   = shift_reg[2:0];
                        state_next = ST_DATA;
                    end
                    ST_DATA:
                    begin
                        // Index three and unmapped indexes drop the byte
                        if (ptr_reg != I2CRG_RO_INDEX && ptr_reg <= I2CRG_LAST_INDEX)
                            regs_next[ptr_reg] = shift_reg;
                        state_next = ST_REGA;
                    end
                    ST_READ:
                    begin
                        tx_next    = rd_byte;
                        tx_en_next = 1'b1;
                    end
                    default: state_next = ST_IGNORE;
                endcase
            end
            else if (scl_fall && state_reg == ST_READ && cnt_reg != 4'h0)
                tx_next = {tx_reg[6:0], 1'b1};
        end
    end
    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= 4'h0;
            in_ack_reg    <= 1'b0;
            ack_drive_reg <= 1'b0;
            shift_reg     <= 8'h00;
            tx_reg        <= 8'hff;
            tx_en_reg     <= 1'b0;
            ptr_reg       <= 3'h0;
            hs_reg        <= 1'b0;
            for (int i = 0; i < I2CRG_NUM_REGS; i++)
                regs_reg[i] <= reset_value(i);
        end
        else
        begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            in_ack_reg    <= in_ack_next;
            ack_drive_reg <= ack_drive_next;
            shift_reg     <= shift_next;
            tx_reg        <= tx_next;
            tx_en_reg     <= tx_en_next;
            ptr_reg       <= ptr_next;
            hs_reg        <= hs_next;
            for (int i = 0; i < I2CRG_NUM_REGS; i++)
                regs_reg[i] <= regs_next[i];
        end
    end
    // ==========================================================
    // Outputs; the pin only ever pulls low
    assign sda_o                  = 1'b0;
    assign sda_oe_o               = ack_drive_reg | (tx_en_reg & ~tx_reg[7]);
    assign status_ctrl_o          = regs_reg[0];
    assign control_o              = regs_reg[1];
    assign batt_volt_o            = regs_reg[2];
    assign charge_cur_o           = regs_reg[4];
    assign high_speed_operation_o = hs_reg;
    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);
    sequence s_addr_ack_end;
        ack_end && state_reg == ST_ADDR && addr_match && !shift_reg[I2CRG_RW_BIT];
    endsequence
    sequence s_data_ack_end;
        ack_end && state_reg == ST_DATA;
    endsequence
    AST_START_ADDR: assert property (start_det && !stop_det |=> state_reg == ST_ADDR)
        else $error("START did not open the address byte");
    AST_ADDR_ACK: assert property (ack_start && state_reg == ST_ADDR && addr_match
                                   |=> ack_drive_reg && sda_oe_o)
        else $error("Matching address not acknowledged");
    AST_REGA_NEXT: assert property (s_addr_ack_end |=> state_reg == ST_REGA)
        else $error("Write address not followed by register address");
    AST_PTR_LOW: assert property (ack_end && state_reg == ST_REGA
                                  |=> ptr_reg == $past(shift_reg[2:0]))
        else $error("Pointer not taken from low three bits");
    AST_COMMIT: assert property (s_data_ack_end ##0 (ptr_reg == 3'h1)
                                 |=> control_o == $past(shift_reg))
        else $error("Data byte not committed at acknowledge end");
    AST_RO_KEEP: assert property (s_data_ack_end ##0 (ptr_reg == I2CRG_RO_INDEX)
                                  |=> $stable(status_ctrl_o) && $stable(control_o)
                                      && $stable(batt_volt_o) && $stable(charge_cur_o))
        else $error("Write to read-only index changed a register");
    AST_PAIRS: assert property (s_data_ack_end |=> state_reg == ST_REGA)
        else $error("Data byte not followed by register address");
    AST_UNMAPPED: assert property (ack_end && state_reg == ST_READ && ptr_reg > 3'h4
                                   |=> tx_reg == 8'hff)
        else $error("Unmapped read not ff");
    AST_HS_CODE: assert property (ack_start && state_reg == ST_ADDR && hs_code
                                  |=> hs_reg && !ack_drive_reg)
        else $error("High-speed code handled wrongly");
    AST_HS_STOP: assert property (stop_det |=> !hs_reg)
        else $error("STOP did not end high-speed operation");
    AST_IGNORE_REL: assert property (state_reg == ST_IGNORE |-> !sda_oe_o)
        else $error("Data line driven while ignoring");
endmodule

// >>> tb/i2c_slave_register_addressing_tb.sv
// Self-checking bench for the serial register target
`timescale 1ns/1ps
module i2c_slave_register_addressing_tb
    import i2crg_pkg::*;
;
    // ==========================================================
    // Signals
    localparam logic [7:0] IDENT_VAL = 8'h4d; // Arbitrary read-only content
    logic       mclk, rstn, scl, m_low, sda_line, sda_o_w, sda_oe, hs, ack;
    logic [7:0] ident, r0, r1, r2, r4, d;
    logic [7:0] exp_val [0:4];
    int         miscompares, n_tests, cycles;
    // Open-drain wire with pull-up: low if any party pulls
    assign sda_line = ~(m_low | (sda_oe & ~sda_o_w));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    i2crg_target dut (.mclk_i(mclk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o_w), .sda_oe_o(sda_oe), .ident_i(ident), .status_ctrl_o(r0),
        .control_o(r1), .batt_volt_o(r2), .charge_cur_o(r4), .high_speed_operation_o(hs));
    i2crg_master_model mst (.mclk_i(mclk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(m_low));
    // ==========================================================
    // Helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] reg_out(input int k);
        // Index three has no output, so fold the writable ones to catch a stray write
        return (k == 0) ? r0 : (k == 1) ? r1 : (k == 2) ? r2 : (k == 4) ? r4 : (r0 ^ r1 ^ r2 ^ r4);
    endfunction
    task automatic write_pair(input int k, input logic [7:0] v);
        logic [7:0] old;
        mst.write_byte(8'(k), ack);
        check({7'h0, ack}, 8'h01);
        old = reg_out(k);
        mst.write_byte(v, ack);
        check({7'h0, ack}, 8'h01);
        check(reg_out(k), old);
        mst.wait_clk(6);
        if (k != 3)
            exp_val[k] = v;
        check(reg_out(k), (k == 3) ? old : v);
    endtask
    // ==========================================================
    // Scenarios
    task automatic reset_values();
        check(r0, I2CRG_RST_REG0);
        check(r1, I2CRG_RST_REG1);
        check(r2, I2CRG_RST_REG2);
        check(r4, I2CRG_RST_REG4);
    endtask
    task automatic wrong_address();
        for (int i = 0; i < 7; i++)
        begin
            mst.start_cond();
            mst.write_byte({I2CRG_SLAVE_ADDR ^ 7'(1 << i), 1'b0}, ack);
            check({7'h0, ack}, 8'h00);
            mst.write_byte(8'h01, ack);
            check({7'h0, ack}, 8'h00);
            mst.write_byte(8'hee, ack);
            mst.stop_cond();
            check(r1, I2CRG_RST_REG1);
        end
    endtask
    // Several pairs after one address, read-only index second
    task automatic write_pairs();
        mst.start_cond();
        mst.write_byte({I2CRG_SLAVE_ADDR, 1'b0}, ack);
        check({7'h0, ack}, 8'h01);
        write_pair(0, 8'ha5);
        write_pair(3, 8'h96);
        write_pair(1, 8'h3c);
        write_pair(2, 8'h5a);
        write_pair(4, 8'hc3);
        mst.stop_cond();
    endtask
    task automatic hs_code();
        mst.start_cond();
        mst.write_byte(8'h0b, ack);
        check({7'h0, ack}, 8'h00);
        mst.wait_clk(6);
        check({7'h0, hs}, 8'h01);
        mst.start_cond();
        mst.write_byte({I2CRG_SLAVE_ADDR, 1'b0}, ack);
        check({7'h0, ack}, 8'h01);
        write_pair(1, 8'h77);
        mst.stop_cond();
        mst.wait_clk(6);
        check({7'h0, hs}, 8'h00);
    endtask
    // Pointer set by a write, then repeated START and two read bytes
    task automatic read_back();
        for (int k = 0; k < 8; k++)
        begin
            mst.start_cond();
            mst.write_byte({I2CRG_SLAVE_ADDR, 1'b0}, ack);
            mst.write_byte(8'(k), ack);
            mst.start_cond();
            mst.write_byte({I2CRG_SLAVE_ADDR, 1'b1}, ack);
            check({7'h0, ack}, 8'h01);
            for (int n = 0; n < 2; n++)
            begin
                mst.read_byte(n == 1, d);
                check(d, (k > 4) ? 8'hff : (k == 3) ? IDENT_VAL : exp_val[k]);
            end
            mst.stop_cond();
        end
    endtask
    // ==========================================================
    // Sequence and closing
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Full run needs well under 10000 cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            report_and_stop();
        end
    end
    initial
    begin
        rstn = 1'b0;
        ident = IDENT_VAL;
        repeat (20) @(posedge mclk);
        #1 rstn = 1'b1;
        mst.wait_clk(10);
        reset_values();
        wrong_address();
        write_pairs();
        hs_code();
        read_back();
        report_and_stop();
    end
endmodule

// >>> tb/i2crg_master_model.sv
// Behavioural bus master for the serial register target
`timescale 1ns/1ps
// ==========================================================
// Master side of the two-wire bus, paced by the system clock
module i2crg_master_model
(
    // Clock
    input  wire logic mclk_i,
    // Bus pins
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    initial
    begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // Data moves mid-low so it never changes while SCL is high
    task automatic xfer_bit(input logic b, output logic r);
        wait_clk(2);
        sda_low_o = ~b;
        wait_clk(2);
        scl_o = 1'b1;
        wait_clk(3);
        @(negedge mclk_i);
        r = sda_i;
        wait_clk(1);
        scl_o = 1'b0;
    endtask
    // Also used as a repeated START from SCL low
    task automatic start_cond();
        wait_clk(2);
        sda_low_o = 1'b0;
        wait_clk(2);
        scl_o = 1'b1;
        wait_clk(4);
        sda_low_o = 1'b1;
        wait_clk(4);
        scl_o = 1'b0;
    endtask
    task automatic stop_cond();
        wait_clk(2);
        sda_low_o = 1'b1;
        wait_clk(2);
        scl_o = 1'b1;
        wait_clk(4);
        sda_low_o = 1'b0;
        wait_clk(4);
    endtask
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask
    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            xfer_bit(1'b1, r);
            d[i] = r;
        end
        xfer_bit(nack, r);
    endtask
endmodule
